// File: rtl/eis_pkg.sv
package eis_pkg;
   localparam int          ADDR_W       = 5;
   localparam int          CNT_W        = 8;
   localparam logic [4:0]  OFS_OVF      = 5'h1d;
   localparam logic [4:0]  OFS_MISC     = 5'h1e;
   localparam logic [4:0]  OFS_LATCH    = 5'h1f;
   localparam logic [7:0]  RST_WORD     = 8'h00;
   localparam logic [7:0]  USED_OVF     = 8'hdf;
   localparam logic [7:0]  USED_MISC    = 8'hff;
   localparam logic [7:0]  USED_LATCH   = 8'hee;
   localparam int          BIT_FAS      = 7;
   localparam int          BIT_CRC      = 6;
   localparam int          BIT_EBIT     = 4;
   localparam int          BIT_LCV      = 3;
   localparam int          BIT_PRBS     = 2;
   localparam int          BIT_PRBSMF   = 1;
   localparam int          BIT_SA       = 0;
   localparam int          BIT_HDLC0    = 7;
   localparam int          BIT_HDLC2    = 5;
   localparam int          BIT_JA       = 4;
   localparam int          BIT_SEC1     = 3;
   localparam int          BIT_SEC5     = 2;
   localparam int          BIT_RCR      = 1;
   localparam int          BIT_SIG      = 0;
   localparam int          JA_MARGIN    = 4;
endpackage : eis_pkg

// File: rtl/eis_flag_cell.sv
`timescale 1ns/10ps
// Sticky flag: set has priority over a clearing read
module eis_flag_cell (
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic set_i,
   input  wire logic clr_i,
   output logic      q
);
   logic q_r;
   logic q_nxt;

   always_comb begin
      if (set_i) begin
         q_nxt = 1'b1;
      end else if (clr_i) begin
         q_nxt = 1'b0;
      end else begin
         q_nxt = q_r;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         q_r <= 1'b0;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign q = q_r;
endmodule : eis_flag_cell

// File: rtl/eis_wrap_detect.sv
`timescale 1ns/10ps
// Pulses one cycle when the watched counter moves from all ones to zero
module eis_wrap_detect #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic [W-1:0] cnt,
   output logic              wrap
);
   logic [W-1:0] prev_r;
   logic [W-1:0] prev_nxt;

   always_comb begin
      prev_nxt = cnt;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         prev_r <= '0;
      end else begin
         prev_r <= prev_nxt;
      end
   end

   // Reset value zero avoids a false wrap on the first cycle
   assign wrap = (prev_r == {W{1'b1}}) && (cnt == '0);
endmodule : eis_wrap_detect

// File: rtl/eis_status_top.sv
`timescale 1ns/10ps
module eis_status_top
   import eis_pkg::*;
#(
   parameter int CNT_BITS = eis_pkg::CNT_W,
   parameter int JA_AW    = 5,
   parameter int JA_DEPTH = 32
) (
   input  wire logic                       clk,
   input  wire logic                       srst,
   input  wire logic [eis_pkg::ADDR_W-1:0] cpu_addr,
   input  wire logic                       cpu_rd,
   output logic [7:0]                      cpu_rdata,
   input  wire logic [CNT_BITS-1:0]        fas_err_cnt,
   input  wire logic [CNT_BITS-1:0]        crc_err_cnt,
   input  wire logic [CNT_BITS-1:0]        ebit_err_cnt,
   input  wire logic [CNT_BITS-1:0]        line_viol_cnt,
   input  wire logic [CNT_BITS-1:0]        prbs_err_cnt,
   input  wire logic [CNT_BITS-1:0]        prbs_mf_cnt,
   input  wire logic [7:0]                 ovf_mask,
   input  wire logic [3:0]                 misc_mask,
   input  wire logic                       sa_bit_or_nibble_sel,
   input  wire logic [3:0]                 sa_bits,
   input  wire logic [3:0]                 sa_nibble,
   input  wire logic                       sa_nibble_stb,
   input  wire logic [2:0]                 hdlc_int,
   input  wire logic [JA_AW:0]             ja_fill,
   input  wire logic                       one_second_status,
   input  wire logic                       five_second_status,
   input  wire logic                       remote_alarm_evt,
   input  wire logic                       crc_err_evt,
   input  wire logic [3:0]                 sig_pattern,
   input  wire logic                       sig_stb,
   input  wire logic                       signaling_debounce_en
);
   import eis_pkg::*;

   // Same-clock framer logic drives every input; no synchronisers needed
   localparam logic [JA_AW:0] JA_LO = (JA_AW+1)'(JA_MARGIN);
   localparam logic [JA_AW:0] JA_HI = (JA_AW+1)'(JA_DEPTH - JA_MARGIN);

   logic [5:0]  wrap;
   logic [7:0]  ovf_word;
   logic [7:0]  misc_word;
   logic [7:0]  latch_word;
   logic [7:0]  ovf_set;
   logic [7:0]  misc_set;
   logic [7:0]  latch_set;
   logic        rd_ovf;
   logic        rd_misc;
   logic        rd_latch;
   logic        sa_chg;
   logic        sig_chg;
   logic        ja_near;

   logic [3:0]  sa_prev_r;
   logic [3:0]  sa_prev_nxt;
   logic [3:0]  nib_prev_r;
   logic [3:0]  nib_prev_nxt;
   logic [3:0]  sig_prev_r;
   logic [3:0]  sig_prev_nxt;
   logic [3:0]  sig_cand_r;
   logic [3:0]  sig_cand_nxt;
   logic        sec1_prev_r;
   logic        sec1_prev_nxt;
   logic        sec5_prev_r;
   logic        sec5_prev_nxt;
   logic [7:0]  cpu_rdata_r;
   logic [7:0]  cpu_rdata_nxt;

   eis_wrap_detect #(.W(CNT_BITS)) u_wrap_fas (
      .clk  (clk),
      .srst (srst),
      .cnt  (fas_err_cnt),
      .wrap (wrap[0])
   );
   eis_wrap_detect #(.W(CNT_BITS)) u_wrap_crc (
      .clk  (clk),
      .srst (srst),
      .cnt  (crc_err_cnt),
      .wrap (wrap[1])
   );
   eis_wrap_detect #(.W(CNT_BITS)) u_wrap_ebit (
      .clk  (clk),
      .srst (srst),
      .cnt  (ebit_err_cnt),
      .wrap (wrap[2])
   );
   eis_wrap_detect #(.W(CNT_BITS)) u_wrap_lcv (
      .clk  (clk),
      .srst (srst),
      .cnt  (line_viol_cnt),
      .wrap (wrap[3])
   );
   eis_wrap_detect #(.W(CNT_BITS)) u_wrap_prbs (
      .clk  (clk),
      .srst (srst),
      .cnt  (prbs_err_cnt),
      .wrap (wrap[4])
   );
   eis_wrap_detect #(.W(CNT_BITS)) u_wrap_prbsmf (
      .clk  (clk),
      .srst (srst),
      .cnt  (prbs_mf_cnt),
      .wrap (wrap[5])
   );

   assign rd_ovf   = cpu_rd && (cpu_addr == OFS_OVF);
   assign rd_misc  = cpu_rd && (cpu_addr == OFS_MISC);
   assign rd_latch = cpu_rd && (cpu_addr == OFS_LATCH);

   // Change detectors for Sa, signaling and status edges
   always_comb begin
      sa_prev_nxt   = sa_bits;
      nib_prev_nxt  = nib_prev_r;
      sig_prev_nxt  = sig_prev_r;
      sig_cand_nxt  = sig_cand_r;
      sec1_prev_nxt = one_second_status;
      sec5_prev_nxt = five_second_status;
      sig_chg       = 1'b0;
      if (sa_nibble_stb) begin
         nib_prev_nxt = sa_nibble;
      end
      if (sig_stb) begin
         sig_cand_nxt = sig_pattern;
         // Debounce needs the new pattern on two strobes running
         if (sig_pattern != sig_prev_r &&
             (!signaling_debounce_en || sig_pattern == sig_cand_r)) begin
            sig_chg      = 1'b1;
            sig_prev_nxt = sig_pattern;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         sa_prev_r   <= 4'h0;
         nib_prev_r  <= 4'h0;
         sig_prev_r  <= 4'h0;
         sig_cand_r  <= 4'h0;
         sec1_prev_r <= 1'b0;
         sec5_prev_r <= 1'b0;
      end else begin
         sa_prev_r   <= sa_prev_nxt;
         nib_prev_r  <= nib_prev_nxt;
         sig_prev_r  <= sig_prev_nxt;
         sig_cand_r  <= sig_cand_nxt;
         sec1_prev_r <= sec1_prev_nxt;
         sec5_prev_r <= sec5_prev_nxt;
      end
   end

   assign sa_chg = sa_bit_or_nibble_sel ? (sa_bits != sa_prev_r) :
                   (sa_nibble_stb && sa_nibble != nib_prev_r);
   assign ja_near = (ja_fill <= JA_LO) || (ja_fill >= JA_HI);

   always_comb begin
      ovf_set              = 8'h00;
      ovf_set[BIT_FAS]     = wrap[0];
      ovf_set[BIT_CRC]     = wrap[1];
      ovf_set[BIT_EBIT]    = wrap[2];
      ovf_set[BIT_LCV]     = wrap[3];
      ovf_set[BIT_PRBS]    = wrap[4];
      ovf_set[BIT_PRBSMF]  = wrap[5];
      ovf_set[BIT_SA]      = sa_chg;
      ovf_set              = ovf_set & ovf_mask & USED_OVF;

      misc_set                      = 8'h00;
      misc_set[BIT_HDLC0:BIT_HDLC2] = {hdlc_int[0], hdlc_int[1], hdlc_int[2]};
      misc_set[BIT_JA]   = ja_near && misc_mask[BIT_JA - 1] ;
      misc_set[BIT_SEC1] = one_second_status && !sec1_prev_r && misc_mask[BIT_SEC1-1];
      misc_set[BIT_SEC5] = five_second_status && !sec5_prev_r && misc_mask[BIT_SEC5-1];
      misc_set[BIT_RCR]  = remote_alarm_evt && crc_err_evt && misc_mask[BIT_RCR-1];
      misc_set[BIT_SIG]  = sig_chg && misc_mask[BIT_SIG];
      misc_set           = misc_set & USED_MISC;

      // Latches follow the raw overflow, independent of the masks
      latch_set             = 8'h00;
      latch_set[BIT_FAS]    = wrap[0];
      latch_set[BIT_CRC]    = wrap[1];
      latch_set[BIT_EBIT+1] = wrap[2];
      latch_set[BIT_LCV]    = wrap[3];
      latch_set[BIT_PRBS]   = wrap[4];
      latch_set[BIT_PRBSMF] = wrap[5];
      latch_set             = latch_set & USED_LATCH;
   end

   for (genvar i = 0; i < 8; i++) begin : g_flags
      eis_flag_cell u_ovf (
         .clk   (clk),
         .srst  (srst),
         .set_i (ovf_set[i]),
         .clr_i (rd_ovf),
         .q     (ovf_word[i])
      );
      eis_flag_cell u_misc (
         .clk   (clk),
         .srst  (srst),
         .set_i (misc_set[i]),
         .clr_i (rd_misc),
         .q     (misc_word[i])
      );
      eis_flag_cell u_latch (
         .clk   (clk),
         .srst  (srst),
         .set_i (latch_set[i]),
         .clr_i (rd_latch),
         .q     (latch_word[i])
      );
   end

   // Read data holds only for the cycle after the strobe; no write path
   always_comb begin
      cpu_rdata_nxt = RST_WORD;
      if (rd_ovf) begin
         cpu_rdata_nxt = ovf_word & USED_OVF;
      end else if (rd_misc) begin
         cpu_rdata_nxt = misc_word & USED_MISC;
      end else if (rd_latch) begin
         cpu_rdata_nxt = latch_word & USED_LATCH;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cpu_rdata_r <= RST_WORD;
      end else begin
         cpu_rdata_r <= cpu_rdata_nxt;
      end
   end

   assign cpu_rdata = cpu_rdata_r;

   property p_fas_ovf;
      @(posedge clk) disable iff (srst)
      (fas_err_cnt == '0 && $past(fas_err_cnt) == '1 && ovf_mask[7]) |=> ovf_word[7];
   endproperty
   a_fas_ovf: assert property (p_fas_ovf) else $error("fas overflow flag missed");

   property p_crc_ovf;
      @(posedge clk) disable iff (srst)
      (crc_err_cnt == '0 && $past(crc_err_cnt) == '1 && ovf_mask[6]) |=> ovf_word[6];
   endproperty
   a_crc_ovf: assert property (p_crc_ovf) else $error("crc overflow flag missed");

   property p_sa_bit;
      @(posedge clk) disable iff (srst)
      (sa_bit_or_nibble_sel && ovf_mask[0] && sa_bits != $past(sa_bits)) |=> ovf_word[0];
   endproperty
   a_sa_bit: assert property (p_sa_bit) else $error("sa change flag missed");

   property p_rd_clear;
      @(posedge clk) disable iff (srst)
      (rd_misc && misc_set == 8'h00) |=> misc_word == 8'h00;
   endproperty
   a_rd_clear: assert property (p_rd_clear) else $error("read did not clear word");

   property p_hdlc;
      @(posedge clk) disable iff (srst)
      hdlc_int[2] |=> misc_word[5];
   endproperty
   a_hdlc: assert property (p_hdlc) else $error("hdlc summary flag missed");

   property p_sec1;
      @(posedge clk) disable iff (srst)
      ($rose(one_second_status) && misc_mask[2]) |=> misc_word[3];
   endproperty
   a_sec1: assert property (p_sec1) else $error("one second flag missed");

   property p_sec5;
      @(posedge clk) disable iff (srst)
      ($rose(five_second_status) && misc_mask[1]) |=> misc_word[2];
   endproperty
   a_sec5: assert property (p_sec5) else $error("five second flag missed");

   property p_ja_near;
      @(posedge clk) disable iff (srst)
      (ja_fill >= JA_HI && misc_mask[3]) |=> misc_word[4];
   endproperty
   a_ja_near: assert property (p_ja_near) else $error("jitter margin flag missed");

   property p_rcr;
      @(posedge clk) disable iff (srst)
      (remote_alarm_evt && crc_err_evt && misc_mask[0]) |=> misc_word[1];
   endproperty
   a_rcr: assert property (p_rcr) else $error("remote alarm flag missed");

   property p_latch;
      @(posedge clk) disable iff (srst)
      (prbs_mf_cnt == '0 && $past(prbs_mf_cnt) == '1) |=> latch_word[1];
   endproperty
   a_latch: assert property (p_latch) else $error("overflow latch missed");

   property p_masked;
      @(posedge clk) disable iff (srst)
      (!ovf_mask[3] && !rd_ovf && !ovf_word[3]) |=> !ovf_word[3];
   endproperty
   a_masked: assert property (p_masked) else $error("masked flag was set");

   property p_unused;
      @(posedge clk) disable iff (srst)
      $past(rd_latch) |-> (cpu_rdata[4] == 1'b0 && cpu_rdata[0] == 1'b0);
   endproperty
   a_unused: assert property (p_unused) else $error("unused bit read nonzero");

   property p_set_wins;
      @(posedge clk) disable iff (srst)
      (rd_misc && hdlc_int[0]) |=> misc_word[7] ##1 (cpu_rdata[7] || !$past(rd_misc));
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost at clear");
endmodule : eis_status_top

// File: bench/testbench.sv
`timescale 1ns/10ps
module testbench;
   import eis_pkg::*;
   localparam int DEPTH = 32;
   logic                clk;
   logic                srst;
   logic [ADDR_W-1:0]   cpu_addr;
   logic                cpu_rd;
   logic [7:0]          cpu_rdata;
   logic [7:0]          cnt [6];
   logic [7:0]          ovf_mask;
   logic [3:0]          misc_mask;
   logic                sa_sel;
   logic [3:0]          sa_bits;
   logic [3:0]          sa_nibble;
   logic                sa_stb;
   logic [2:0]          hdlc_int;
   logic [5:0]          ja_fill;
   logic                sec1;
   logic                sec5;
   logic                ra_evt;
   logic                ce_evt;
   logic [3:0]          sig_pattern;
   logic                sig_stb;
   logic                db_en;
   logic                rd_seen;
   logic [31:0]         seed;
   logic [5:0]          s;
   logic [7:0]          m;
   logic [3:0]          mm;
   logic [ADDR_W-1:0]   qa [$];
   logic [7:0]          qe [$];
   int                  miscompares;
   int                  compares;

   eis_status_top #(.JA_AW(5), .JA_DEPTH(DEPTH)) dut (
      .clk(clk), .srst(srst), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
      .fas_err_cnt(cnt[0]), .crc_err_cnt(cnt[1]), .ebit_err_cnt(cnt[2]),
      .line_viol_cnt(cnt[3]), .prbs_err_cnt(cnt[4]), .prbs_mf_cnt(cnt[5]),
      .ovf_mask(ovf_mask), .misc_mask(misc_mask), .sa_bit_or_nibble_sel(sa_sel),
      .sa_bits(sa_bits), .sa_nibble(sa_nibble), .sa_nibble_stb(sa_stb),
      .hdlc_int(hdlc_int), .ja_fill(ja_fill), .one_second_status(sec1),
      .five_second_status(sec5), .remote_alarm_evt(ra_evt), .crc_err_evt(ce_evt),
      .sig_pattern(sig_pattern), .sig_stb(sig_stb), .signaling_debounce_en(db_en));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr

   // Counter order: fas, crc, ebit, line violation, prbs, prbs multiframe
   function automatic logic [7:0] ovmap(input logic [5:0] w);
      return {w[0], w[1], 1'b0, w[2], w[3], w[4], w[5], 1'b0};
   endfunction : ovmap

   function automatic logic [7:0] ltmap(input logic [5:0] w);
      return {w[0], w[1], w[2], 1'b0, w[3], w[4], w[5], 1'b0};
   endfunction : ltmap

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic rq(input logic [ADDR_W-1:0] a, input logic [7:0] e);
      @(posedge clk);
      cpu_addr <= a;
      cpu_rd   <= 1'b1;
      qa.push_back(a);
      qe.push_back(e);
   endtask : rq

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
      rq(a, e);
      @(posedge clk);
      cpu_rd <= 1'b0;
   endtask : rd

   task automatic tally_and_finish;
      if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish

   // Read data is only valid in the cycle after the read is taken
   always @(posedge clk) rd_seen <= cpu_rd;
   always @(negedge clk) begin
      if (!srst && rd_seen) begin
         if (qe.size() > 0) begin
            chk($sformatf("reg %h", qa.pop_front()), cpu_rdata, qe.pop_front());
         end else begin
            chk("unexpected read", cpu_rdata, 8'hxx);
         end
      end else if (!srst) chk("idle rdata", cpu_rdata, 8'h00);
   end

   initial begin
      srst = 1'b1; cpu_addr = '0; cpu_rd = 1'b0; ovf_mask = 8'h00; misc_mask = 4'h0;
      foreach (cnt[j]) cnt[j] = 8'h00;
      sa_sel = 1'b1; sa_bits = 4'h0; sa_nibble = 4'h0; sa_stb = 1'b0; hdlc_int = 3'h0;
      ja_fill = 6'd16; sec1 = 1'b0; sec5 = 1'b0; ra_evt = 1'b0; ce_evt = 1'b0;
      sig_pattern = 4'h0; sig_stb = 1'b0; db_en = 1'b0; rd_seen = 1'b0;
      miscompares = 0; compares = 0; seed = 32'he76b;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      rq(OFS_OVF, RST_WORD); rq(OFS_MISC, RST_WORD); rq(OFS_LATCH, RST_WORD);
      rq(5'h00, 8'h00); rd(5'h1c, 8'h00);
      for (int k = 0; k < 5; k++) begin
         seed = lfsr(seed);
         s = (k == 0) ? 6'h3f : seed[5:0];
         m = (k == 1) ? 8'h00 : ((k == 0) ? 8'hfe : seed[15:8]);
         @(posedge clk);
         ovf_mask <= m;
         foreach (cnt[j]) cnt[j] <= 8'hff;
         @(posedge clk);
         foreach (cnt[j]) cnt[j] <= s[j] ? 8'h00 : 8'h01;
         rd(OFS_OVF, ovmap(s) & m & USED_OVF);
         rq(OFS_LATCH, ltmap(s));
         rq(OFS_OVF, 8'h00);
         rd(OFS_LATCH, 8'h00);
      end
      // Wrap lands in the same cycle as the clearing read
      @(posedge clk); ovf_mask <= 8'hff; cnt[0] <= 8'hff;
      @(posedge clk); cnt[0] <= 8'h00;
      @(posedge clk); cnt[0] <= 8'hff;
      rq(OFS_OVF, 8'h80);
      cnt[0] <= 8'h00;
      @(posedge clk); cpu_rd <= 1'b0;
      rd(OFS_OVF, 8'h80);
      rq(OFS_LATCH, 8'h80); rd(OFS_OVF, 8'h00);
      // Sa bit mode, enabled then masked
      @(posedge clk); ovf_mask <= 8'h01; sa_bits <= 4'h4;
      rd(OFS_OVF, 8'h01);
      @(posedge clk); ovf_mask <= 8'h00; sa_bits <= 4'h6;
      rd(OFS_OVF, 8'h00);
      // Nibble mode: history is primed while masked
      @(posedge clk); sa_sel <= 1'b0; sa_nibble <= 4'h5; sa_stb <= 1'b1; sa_bits <= 4'h1;
      @(posedge clk); sa_stb <= 1'b0; ovf_mask <= 8'h01;
      @(posedge clk); sa_stb <= 1'b1;
      @(posedge clk); sa_stb <= 1'b0;
      rd(OFS_OVF, 8'h00);
      @(posedge clk); sa_nibble <= 4'ha; sa_stb <= 1'b1;
      @(posedge clk); sa_stb <= 1'b0;
      rd(OFS_OVF, 8'h01);
      for (int j = 0; j < 3; j++) begin
         @(posedge clk); hdlc_int <= 3'(1 << j);
         @(posedge clk); hdlc_int <= 3'h0;
         rd(OFS_MISC, 8'h80 >> j);
      end
      // Summary event held through the clearing read keeps its flag
      @(posedge clk); hdlc_int <= 3'h1;
      rq(OFS_MISC, 8'h80);
      @(posedge clk); hdlc_int <= 3'h0; cpu_rd <= 1'b0;
      rd(OFS_MISC, 8'h80);
      rd(OFS_MISC, 8'h00);
      for (int k = 0; k < 6; k++) begin
         seed = lfsr(seed);
         mm = (k == 0) ? 4'h0 : ((k == 1) ? 4'hf : seed[3:0]);
         @(posedge clk);
         misc_mask <= mm; ja_fill <= k[0] ? 6'(DEPTH - 4) : 6'd4; sec1 <= 1'b1; sec5 <= 1'b1;
         ra_evt <= 1'b1; ce_evt <= 1'b1; sig_pattern <= sig_pattern ^ 4'h3; sig_stb <= 1'b1;
         @(posedge clk); ja_fill <= 6'd16; ra_evt <= 1'b0; ce_evt <= 1'b0; sig_stb <= 1'b0;
         rd(OFS_MISC, {3'b000, mm, mm[0]});
         sec1 <= 1'b0; sec5 <= 1'b0;
      end
      // Near-miss cases that must not flag
      @(posedge clk); misc_mask <= 4'hf; ja_fill <= 6'd5; ra_evt <= 1'b1; sig_stb <= 1'b1;
      @(posedge clk); ja_fill <= 6'(DEPTH - 5); ra_evt <= 1'b0; ce_evt <= 1'b1; sig_stb <= 1'b0;
      @(posedge clk); ja_fill <= 6'd16; ce_evt <= 1'b0;
      rd(OFS_MISC, 8'h00);
      // Debounced signaling needs the new pattern on two strobes
      @(posedge clk); db_en <= 1'b1; sig_pattern <= sig_pattern ^ 4'h1; sig_stb <= 1'b1;
      @(posedge clk); sig_stb <= 1'b0;
      rd(OFS_MISC, 8'h00);
      @(posedge clk); sig_stb <= 1'b1;
      @(posedge clk); sig_stb <= 1'b0;
      rd(OFS_MISC, 8'h01);
      // Reset in mid-run drops a pending flag
      @(posedge clk); hdlc_int <= 3'h1;
      @(posedge clk); hdlc_int <= 3'h0; srst <= 1'b1;
      @(posedge clk); srst <= 1'b0;
      rd(OFS_MISC, 8'h00);
      for (int i = 0; i < 10 && qe.size() > 0; i++) @(posedge clk);
      if (qe.size() > 0) miscompares++;
      repeat (2) @(posedge clk);
      tally_and_finish();
   end
endmodule : testbench
